// ==== rtl/astx_pkg.sv ====
package astx_pkg;
    localparam int          DATA_BITS     = 8;
    localparam int          DIV_W         = 16;
    localparam int          CNT_W         = 4;
    localparam logic [3:0]  LAST_DATA_IDX = 4'h7;
    localparam logic [7:0]  DIV_RST_HI    = 8'h00;
    localparam logic [7:0]  DIV_RST_LO    = 8'h00;
    localparam logic [15:0] DIV_ONE       = 16'h0001;
    localparam logic        LINE_IDLE     = 1'b1;
    localparam logic        START_LVL     = 1'b0;
    localparam logic        STOP_LVL      = 1'b1;
    localparam logic        CTS_ASSERTED  = 1'b0;

    typedef enum logic [2:0] {
        ASTX_IDLE,
        ASTX_START,
        ASTX_DATA,
        ASTX_NINTH,
        ASTX_STOP1,
        ASTX_STOP2
    } astx_state_t;
endpackage

// ==== rtl/astx_baud_gen.sv ====
module astx_baud_gen
    import astx_pkg::*;
(
    input  wire logic             ref_clk,
    input  wire logic             rst,
    input  wire logic             restart,
    input  wire logic [DIV_W-1:0] divisor,
    output logic                  bit_tick
);
    logic [DIV_W-1:0] cnt_r;
    logic [DIV_W-1:0] cnt_nxt;
    logic             at_end;

    // Divisor of zero behaves as one so the line never freezes
    assign at_end   = (cnt_r + DIV_ONE >= divisor);
    assign cnt_nxt  = (restart || at_end) ? '0 : cnt_r + DIV_ONE;
    assign bit_tick = at_end && !restart;

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

// ==== rtl/astx_transmitter.sv ====
// What this block does
// - Eight data bits, LSB first
// - Low start, one or two high stops
// - Optional even or odd parity bit
// - Shared divider and format, independent transmitter
// - Sixteen-bit divider from high/low bytes
// - Empty flag high when holding free
// - Held byte moves to shifter automatically
// - Interrupt request while holding register free
// - Request immediate after enabling, holding empty
// - Start only while transmit enable set; finish character
// - Parity enable and even/odd select
// - Flow control gates new character starts
// - Multidrop mode gives ninth bit
// - Ninth bit equals outgoing address flag
// - Driver enable output during transmission
// - Clear-to-send sampled before start; finish character
// - Ninth bit after data, before stops
module astx_transmitter
    import astx_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       rst,
    input  wire logic [7:0] baud_div_hi_wdata,
    input  wire logic       baud_div_hi_we,
    input  wire logic [7:0] baud_div_lo_wdata,
    input  wire logic       baud_div_lo_we,
    input  wire logic       tx_enable_bit,
    input  wire logic       parity_enable_bit,
    input  wire logic       parity_odd_select,
    input  wire logic       two_stop_bits,
    input  wire logic       flow_control_enable,
    input  wire logic       multidrop_mode_enable,
    input  wire logic       outgoing_address_flag,
    input  wire logic       tx_irq_enable,
    input  wire logic [7:0] tx_data_wdata,
    input  wire logic       tx_data_we,
    input  wire logic       clear_to_send_n,
    output logic [15:0]     baud_divider,
    output logic            tx_holding_empty_flag,
    output logic            tx_irq,
    output logic            tx_busy,
    output logic            tx_line,
    output logic            driver_enable
);
    astx_state_t      state_r;
    astx_state_t      state_nxt;
    logic [7:0]       div_hi_r;
    logic [7:0]       div_lo_r;
    logic [7:0]       hold_r;
    logic             hold_full_r;
    logic             hold_addr_r;
    logic [7:0]       shift_r;
    logic             ninth_r;
    logic             ninth_en_r;
    logic             stop2_r;
    logic [CNT_W-1:0] bit_idx_r;
    logic             line_r;
    logic             de_r;
    logic             cts_ok_r;
    logic             bit_tick;
    logic             idle;
    logic             start_go;
    logic             load_shift;
    logic             parity_bit;
    logic             ninth_val;
    logic             ninth_used;
    logic             last_data;
    logic             line_nxt;
    logic             data_adv;
    logic             data_bit;

    // Each byte loads alone; rewrite both while idle to avoid a mixed rate
    assign baud_divider = {div_hi_r, div_lo_r};

    astx_baud_gen u_baud (
        .ref_clk  (ref_clk),
        .rst      (rst),
        .restart  (start_go),
        .divisor  (baud_divider),
        .bit_tick (bit_tick)
    );

    assign idle       = (state_r == ASTX_IDLE);
    // Gate uses the level registered one clock earlier
    assign start_go   = idle && hold_full_r && tx_enable_bit
                        && (!flow_control_enable || cts_ok_r);
    assign load_shift = start_go;
    assign parity_bit = (^hold_r) ^ parity_odd_select;
    assign ninth_val  = multidrop_mode_enable ? hold_addr_r : parity_bit;
    assign ninth_used = multidrop_mode_enable || parity_enable_bit;
    assign last_data  = (bit_idx_r == LAST_DATA_IDX);
    // Step to the next bit only on the tick that ends the current one
    assign data_adv   = (state_r == ASTX_DATA) && bit_tick;
    assign data_bit   = data_adv ? shift_r[1] : shift_r[0];

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ASTX_IDLE:  if (start_go) state_nxt = ASTX_START;
            ASTX_START: if (bit_tick) state_nxt = ASTX_DATA;
            ASTX_DATA: begin
                if (bit_tick && last_data) begin
                    state_nxt = ninth_en_r ? ASTX_NINTH : ASTX_STOP1;
                end
            end
            ASTX_NINTH: if (bit_tick) state_nxt = ASTX_STOP1;
            ASTX_STOP1: begin
                if (bit_tick) begin
                    state_nxt = stop2_r ? ASTX_STOP2 : ASTX_IDLE;
                end
            end
            ASTX_STOP2: if (bit_tick) state_nxt = ASTX_IDLE;
            default:    state_nxt = ASTX_IDLE;
        endcase
    end

    always_comb begin
        case (state_nxt)
            ASTX_START: line_nxt = START_LVL;
            ASTX_DATA:  line_nxt = data_bit;
            ASTX_NINTH: line_nxt = ninth_r;
            ASTX_STOP1: line_nxt = STOP_LVL;
            ASTX_STOP2: line_nxt = STOP_LVL;
            default:    line_nxt = LINE_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_hi_r <= DIV_RST_HI;
        end else if (baud_div_hi_we) begin
            div_hi_r <= baud_div_hi_wdata;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_lo_r <= DIV_RST_LO;
        end else if (baud_div_lo_we) begin
            div_lo_r <= baud_div_lo_wdata;
        end
    end

    // Write while full is ignored unless the shifter loads in the same cycle; software must poll the flag first
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            hold_full_r <= 1'b0;
            hold_r      <= '0;
            hold_addr_r <= 1'b0;
        end else if (tx_data_we && (!hold_full_r || load_shift)) begin
            hold_full_r <= 1'b1;
            hold_r      <= tx_data_wdata;
            hold_addr_r <= outgoing_address_flag;
        end else if (load_shift) begin
            hold_full_r <= 1'b0;
        end
    end

    // Format and stop count latched here, so changes wait for the next frame
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            shift_r    <= '0;
            ninth_r    <= 1'b0;
            ninth_en_r <= 1'b0;
            stop2_r    <= 1'b0;
            bit_idx_r  <= '0;
        end else if (load_shift) begin
            shift_r    <= hold_r;
            ninth_r    <= ninth_val;
            ninth_en_r <= ninth_used;
            stop2_r    <= two_stop_bits;
            bit_idx_r  <= '0;
        end else if (data_adv) begin
            shift_r   <= {1'b0, shift_r[7:1]};
            bit_idx_r <= bit_idx_r + 4'h1;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            state_r <= ASTX_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Line and driver enable move on the same edge as the state
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            line_r <= LINE_IDLE;
        end else begin
            line_r <= line_nxt;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            de_r <= 1'b0;
        end else begin
            de_r <= (state_nxt != ASTX_IDLE);
        end
    end

    // One register stage is the clock of look-ahead before a start
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            cts_ok_r <= 1'b0;
        end else begin
            cts_ok_r <= (clear_to_send_n == CTS_ASSERTED);
        end
    end

    assign tx_line               = line_r;
    assign driver_enable         = de_r;
    assign tx_busy               = !idle;
    assign tx_holding_empty_flag = !hold_full_r;
    assign tx_irq = tx_irq_enable && tx_enable_bit && !hold_full_r;
endmodule

// ==== test/astx_monitor.sv ====
module astx_monitor
    import astx_pkg::*;
(
    input wire logic        ref_clk,
    input wire logic        rst,
    input wire logic        tx_enable_bit,
    input wire logic        flow_control_enable,
    input wire logic        tx_irq_enable,
    input wire logic        tx_data_we,
    input wire logic        clear_to_send_n,
    input wire logic [15:0] baud_divider,
    input wire logic        tx_holding_empty_flag,
    input wire logic        tx_irq,
    input wire logic        tx_busy,
    input wire logic        tx_line,
    input wire logic        driver_enable
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    sequence launch;
        $rose(tx_busy);
    endsequence
    idle_high_a: assert property ((!tx_busy) [*3] |-> tx_line)
        else $error("line low while idle");
    start_low_a: assert property (launch |-> !tx_line)
        else $error("no start bit after load");
    drv_en_a: assert property (driver_enable == tx_busy)
        else $error("driver enable differs from frame");
    irq_level_a: assert property (
        tx_irq == (tx_irq_enable && tx_enable_bit && tx_holding_empty_flag))
        else $error("irq level wrong");
    take_write_a: assert property (
        tx_data_we && tx_holding_empty_flag |=> !tx_holding_empty_flag)
        else $error("write not taken");
    en_gate_a: assert property (launch |-> $past(tx_enable_bit))
        else $error("frame started while disabled");
    cts_gate_a: assert property (
        launch ##0 flow_control_enable |-> $past(clear_to_send_n, 2) == CTS_ASSERTED)
        else $error("cts ignored");
    load_start_a: assert property ($rose(tx_holding_empty_flag) |-> !tx_line)
        else $error("load without start");
    start_len_a: assert property (
        $fell(tx_line) && baud_divider == 16'h0004 |-> (!tx_line) [*4])
        else $error("bit shorter than divisor");
endmodule

// ==== test/astx_rx_model.sv ====
module astx_rx_model (
    input wire logic   ref_clk,
    input wire logic   tx_line,
    input wire logic   hold,
    input var int      nbits,
    output logic       clear_to_send_n,
    output logic [11:0] frames [8],
    output int         n_frames
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] f;
    // Hold high stalls the sender before its next character
    assign clear_to_send_n = hold;
    initial begin
        n_frames = 0;
        forever begin
            @(negedge tx_line);
            f = 12'hfff;
            #1;
            repeat (2) @(posedge ref_clk);
            // Mid-bit sampling with divisor 4
            for (int i = 0; i < nbits; i++) begin
                #1 f[i] = tx_line;
                if (i < nbits - 1) repeat (4) @(posedge ref_clk);
            end
            frames[n_frames % 8] = f;
            n_frames++;
        end
    end
endmodule

// ==== test/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic       ref_clk = 0, rst = 1, hold = 0, tx_data_we = 0;
    logic       baud_div_hi_we = 0, baud_div_lo_we = 0, tx_enable_bit = 1;
    logic       parity_enable_bit = 0, parity_odd_select = 0, two_stop_bits = 0;
    logic       flow_control_enable = 0, multidrop_mode_enable = 0;
    logic       outgoing_address_flag = 0, tx_irq_enable = 1, clear_to_send_n;
    logic [7:0] baud_div_hi_wdata = 8'h12, baud_div_lo_wdata = 8'h04, tx_data_wdata = 8'h00;
    logic [15:0] baud_divider;
    logic       tx_holding_empty_flag, tx_irq, tx_busy, tx_line, driver_enable;
    logic [11:0] frames [8];
    int         n_frames, nbits = 10, n_errors = 0, total_checks = 0;
    logic [4:0] modes [5] = '{5'b00000, 5'b00100, 5'b01100, 5'b00011, 5'b00010};
    astx_transmitter dut (.ref_clk, .rst, .baud_div_hi_wdata, .baud_div_hi_we,
        .baud_div_lo_wdata, .baud_div_lo_we, .tx_enable_bit, .parity_enable_bit,
        .parity_odd_select, .two_stop_bits, .flow_control_enable, .multidrop_mode_enable,
        .outgoing_address_flag, .tx_irq_enable, .tx_data_wdata, .tx_data_we,
        .clear_to_send_n, .baud_divider, .tx_holding_empty_flag, .tx_irq, .tx_busy,
        .tx_line, .driver_enable);
    astx_rx_model rx (.ref_clk, .tx_line, .hold, .nbits, .clear_to_send_n, .frames, .n_frames);
    initial begin
        forever #12.5 ref_clk = ~ref_clk;
    end
    task automatic step;
        @(posedge ref_clk);
        #2;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Mode word is {two stops, odd, parity, multidrop, address}
    function automatic logic [11:0] exp_frame(input logic [7:0] d, input logic [4:0] m);
        exp_frame = {2'b11, m[1] ? m[0] : ^d ^ m[3], d, 1'b0};
        if (!m[1] && !m[2]) exp_frame[9] = 1'b1;
    endfunction
    task automatic send(input logic [7:0] d, input logic [4:0] m);
        for (int i = 0; i < 900 && tx_holding_empty_flag !== 1'b1; i++) step;
        {two_stop_bits, parity_odd_select, parity_enable_bit, multidrop_mode_enable,
            outgoing_address_flag} = m;
        nbits = 10 + int'(m[1] | m[2]) + int'(m[4]);
        tx_data_wdata = d;
        tx_data_we = 1;
        step;
        tx_data_we = 0;
    endtask
    task automatic until_frames(input int n);
        for (int i = 0; i < 900 && n_frames < n; i++) step;
    endtask
    // Request is a level; the routine's clear is safe once the write drops it
    task automatic isr_send(input logic [7:0] d);
        for (int i = 0; i < 900 && tx_irq !== 1'b1; i++) step;
        check(tx_irq, 16'h0001);
        send(d, 5'b00000);
        check(tx_irq, 16'h0000);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (16) step;
        rst = 0;
        check(tx_line, 16'h0001);
        check(driver_enable, 16'h0000);
        check(tx_holding_empty_flag, 16'h0001);
        check(baud_divider, 16'h0000);
        check(tx_irq, 16'h0001);
        baud_div_hi_we = 1;
        baud_div_lo_we = 1;
        step;
        baud_div_hi_wdata = 8'h00;
        baud_div_lo_we = 0;
        check(baud_divider, 16'h1204);
        step;
        baud_div_hi_we = 0;
        check(baud_divider, 16'h0004);
        for (int i = 0; i < 5; i++) begin
            send(8'(8'h96 + 37 * i), modes[i]);
            until_frames(i + 1);
            check(frames[i], exp_frame(8'(8'h96 + 37 * i), modes[i]));
        end
        // Two stops back to back: a short stop shows up as an early start
        send(8'hc3, 5'b11100);
        send(8'h3c, 5'b11100);
        until_frames(7);
        check(frames[5], exp_frame(8'hc3, 5'b11100));
        check(frames[6], exp_frame(8'h3c, 5'b11100));
        tx_enable_bit = 0;
        flow_control_enable = 1;
        hold = 1;
        send(8'h5e, 5'b00000);
        repeat (40) step;
        check(tx_holding_empty_flag, 16'h0000);
        check(tx_line, 16'h0001);
        check(tx_irq, 16'h0000);
        tx_enable_bit = 1;
        repeat (40) step;
        check(tx_busy, 16'h0000);
        hold = 0;
        until_frames(8);
        check(frames[7], exp_frame(8'h5e, 5'b00000));
        isr_send(8'ha5);
        until_frames(9);
        check(frames[0], exp_frame(8'ha5, 5'b00000));
        check(tx_irq, 16'h0001);
        tally_and_finish;
    end
    initial begin
        #100us;
        n_errors++;
        tally_and_finish;
    end
endmodule
bind astx_transmitter astx_monitor mon (.ref_clk, .rst, .tx_enable_bit, .flow_control_enable,
    .tx_irq_enable, .tx_data_we, .clear_to_send_n, .baud_divider, .tx_holding_empty_flag,
    .tx_irq, .tx_busy, .tx_line, .driver_enable);
